// *** rtl/rdtmr_pkg.sv ***
/*
 * Constants, field positions and carrier types shared by the reload down timer.
 * Assumes an 8-bit register port with a 2-bit register index.
 */
package rdtmr_pkg;
   // Register indices on the plain register port
   localparam logic [1:0] ADDR_CTRL_UPPER  = 2'h0;
   localparam logic [1:0] ADDR_CTRL_LOWER  = 2'h1;
   localparam logic [1:0] ADDR_VALUE_UPPER = 2'h2;
   localparam logic [1:0] ADDR_VALUE_LOWER = 2'h3;

   // Lower control/status field positions
   localparam int BIT_START  = 0;
   localparam int BIT_ENABLE = 1;
   localparam int BIT_UFLAG  = 2;
   localparam int BIT_IRQEN  = 3;
   localparam int BIT_RELOAD = 4;
   localparam int BIT_OLEVEL = 5;
   localparam int BIT_OUTEN  = 6;

   // Upper control field positions
   localparam int MODE_LSB = 0;
   localparam int CSEL_LSB = 3;

   localparam logic [2:0]  CSEL_EVENT    = 3'h7;
   localparam logic [15:0] COUNT_RESET   = 16'h0000;
   localparam logic [15:0] COUNT_ONESHOT = 16'hffff;
   localparam logic [15:0] RELOAD_RESET  = 16'h0000;
   localparam logic [7:0]  BYTE_ZERO     = 8'h00;
   localparam int          PRESC_WIDTH   = 8;

   typedef enum logic [1:0] {
      RDTMR_STOP = 2'b00,
      RDTMR_WAIT = 2'b01,
      RDTMR_RUN  = 2'b10
   } rdtmr_state_e;

   typedef struct packed {
      logic [2:0] count_clock_select;
      logic [2:0] operating_mode_select;
      logic       output_pin_enable;
      logic       output_level_select;
      logic       reload_select_bit;
      logic       underflow_irq_enable;
   } rdtmr_ctrl_s;

   localparam rdtmr_ctrl_s CTRL_RESET = '{3'h0, 3'h0, 1'b0, 1'b0, 1'b0, 1'b0};
endpackage

// *** rtl/rdtmr_top.sv ***
/*
 * Reload down timer: 16-bit down counter with stop, wait and run states,
 * internal prescaled or external event count clock, trigger starts and gated counting.
 * Assumes the timer input pin is synchronous-safe after two flops, and a
 * register master that issues one-cycle read or write strobes.
 */
`timescale 1ns/10ps

module rdtmr_top #(
   parameter int PRESC_W = rdtmr_pkg::PRESC_WIDTH
) (
   input  wire logic       core_clk_in,
   input  wire logic       srst_in,
   input  wire logic [1:0] reg_addr_in,
   input  wire logic [7:0] reg_wdata_in,
   input  wire logic       reg_wr_in,
   input  wire logic       reg_rd_in,
   output logic      [7:0] reg_rdata_out,
   input  wire logic       timer_input_pin_in,
   output logic            timer_output_pin_out,
   output logic            timer_output_oe_out,
   output logic            irq_out
);

   rdtmr_pkg::rdtmr_state_e state;
   rdtmr_pkg::rdtmr_ctrl_s  ctrl;
   rdtmr_pkg::rdtmr_ctrl_s  next_ctrl;
   logic [15:0]             count;
   logic [15:0]             reload_value_register;
   logic [7:0]              reload_hold;
   logic [7:0]              count_low_latch;
   logic                    count_enable_bit;
   logic                    underflow_flag;
   logic                    start_pending;
   logic [PRESC_W-1:0]      presc;
   logic                    pin_sync1;
   logic                    pin_sync2;
   logic                    pin_prev;
   logic                    wr_lower;
   logic                    next_enable;
   logic                    sw_start;
   logic                    ext_start;
   logic                    start;
   logic                    rise;
   logic                    fall;
   logic                    event_mode;
   logic                    gate_mode;
   logic                    gate_open;
   logic                    tick;
   logic                    underflow;

   // Tick when the low csel+1 bits of the prescaler are all ones
   function automatic logic presc_hit(input logic [PRESC_W-1:0] cnt, input logic [2:0] csel);
      logic [PRESC_W-1:0] mask;
      mask = '0;
      for (int i = 0; i < PRESC_W; i++) begin
         if (i <= int'(csel)) begin
            mask[i] = 1'b1;
         end
      end
      return (cnt & mask) == mask;
   endfunction

   // Edge selection: 01 rising, 10 falling, 11 both, 00 none
   function automatic logic edge_hit(input logic r, input logic f, input logic [1:0] sel);
      return (sel[0] & r) | (sel[1] & f);
   endfunction

   // Pin synchroniser and edge history
   always_ff @(posedge core_clk_in) begin
      if (srst_in) begin
         pin_sync1 <= 1'b0;
         pin_sync2 <= 1'b0;
         pin_prev  <= 1'b0;
      end else begin
         pin_sync1 <= timer_input_pin_in;
         pin_sync2 <= pin_sync1;
         pin_prev  <= pin_sync2;
      end
   end

   assign rise = pin_sync2 & ~pin_prev;
   assign fall = ~pin_sync2 & pin_prev;

   always_comb begin
      next_ctrl = ctrl;
      if (reg_wr_in && reg_addr_in == rdtmr_pkg::ADDR_CTRL_UPPER) begin
         next_ctrl.count_clock_select    = reg_wdata_in[rdtmr_pkg::CSEL_LSB +: 3];
         next_ctrl.operating_mode_select = reg_wdata_in[rdtmr_pkg::MODE_LSB +: 3];
      end
      if (wr_lower) begin
         next_ctrl.output_pin_enable    = reg_wdata_in[rdtmr_pkg::BIT_OUTEN];
         next_ctrl.output_level_select  = reg_wdata_in[rdtmr_pkg::BIT_OLEVEL];
         next_ctrl.reload_select_bit    = reg_wdata_in[rdtmr_pkg::BIT_RELOAD];
         next_ctrl.underflow_irq_enable = reg_wdata_in[rdtmr_pkg::BIT_IRQEN];
      end
   end

   assign wr_lower    = reg_wr_in && reg_addr_in == rdtmr_pkg::ADDR_CTRL_LOWER;
   assign next_enable = wr_lower ? reg_wdata_in[rdtmr_pkg::BIT_ENABLE] : count_enable_bit;
   assign event_mode  = ctrl.count_clock_select == rdtmr_pkg::CSEL_EVENT;
   assign gate_mode   = ~event_mode & ctrl.operating_mode_select[2];
   assign gate_open   = pin_sync2 == ctrl.operating_mode_select[0];
   // Software start only counts with enable set after this write
   assign sw_start    = wr_lower & reg_wdata_in[rdtmr_pkg::BIT_START] & next_enable;
   // Pin serves only as a trigger outside gate and event modes
   assign ext_start   = (state != rdtmr_pkg::RDTMR_STOP) & ~event_mode & ~gate_mode
                        & edge_hit(rise, fall, ctrl.operating_mode_select[1:0]);
   assign start       = next_enable & (sw_start | ext_start);

   always_comb begin
      if (event_mode) begin
         tick = edge_hit(rise, fall, ctrl.operating_mode_select[1:0]);
      end else begin
         tick = presc_hit(presc, ctrl.count_clock_select)
                & (~gate_mode | gate_open);
      end
   end

   assign underflow = (state == rdtmr_pkg::RDTMR_RUN) & next_enable & ~start & tick
                      & (count == rdtmr_pkg::COUNT_RESET);

   always_ff @(posedge core_clk_in) begin
      if (srst_in) begin
         presc <= '0;
      end else begin
         presc <= presc + 1'b1;
      end
   end

   // Control registers
   always_ff @(posedge core_clk_in) begin
      if (srst_in) begin
         ctrl             <= rdtmr_pkg::CTRL_RESET;
         count_enable_bit <= 1'b0;
      end else begin
         ctrl             <= next_ctrl;
         count_enable_bit <= next_enable;
      end
   end

   // Underflow flag: hardware set wins over a software clear
   always_ff @(posedge core_clk_in) begin
      if (srst_in) begin
         underflow_flag <= 1'b0;
      end else if (underflow) begin
         underflow_flag <= 1'b1;
      end else if (wr_lower && !reg_wdata_in[rdtmr_pkg::BIT_UFLAG]) begin
         underflow_flag <= 1'b0;
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (srst_in) begin
         irq_out <= 1'b0;
      end else begin
         irq_out <= underflow_flag & ctrl.underflow_irq_enable;
      end
   end

   // Reload value: upper byte waits until the lower byte is written
   always_ff @(posedge core_clk_in) begin
      if (srst_in) begin
         reload_hold           <= rdtmr_pkg::BYTE_ZERO;
         reload_value_register <= rdtmr_pkg::RELOAD_RESET;
      end else if (reg_wr_in && reg_addr_in == rdtmr_pkg::ADDR_VALUE_UPPER) begin
         reload_hold <= reg_wdata_in;
      end else if (reg_wr_in && reg_addr_in == rdtmr_pkg::ADDR_VALUE_LOWER) begin
         reload_value_register <= {reload_hold, reg_wdata_in};
      end
   end

   // State machine and down counter
   always_ff @(posedge core_clk_in) begin
      if (srst_in) begin
         state <= rdtmr_pkg::RDTMR_STOP;
         count <= rdtmr_pkg::COUNT_RESET;
      end else if (!next_enable) begin
         state <= rdtmr_pkg::RDTMR_STOP;
      end else if (start) begin
         state <= rdtmr_pkg::RDTMR_RUN;
         count <= reload_value_register;
      end else begin
         case (state)
            rdtmr_pkg::RDTMR_STOP: begin
               state <= rdtmr_pkg::RDTMR_WAIT;
            end
            rdtmr_pkg::RDTMR_WAIT: begin
               state <= rdtmr_pkg::RDTMR_WAIT;
            end
            rdtmr_pkg::RDTMR_RUN: begin
               if (underflow && ctrl.reload_select_bit) begin
                  count <= reload_value_register;
               end else if (underflow) begin
                  count <= rdtmr_pkg::COUNT_ONESHOT;
                  state <= rdtmr_pkg::RDTMR_WAIT;
               end else if (tick) begin
                  count <= count - 16'h0001;
               end
            end
            default: begin
               state <= rdtmr_pkg::RDTMR_STOP;
            end
         endcase
      end
   end

   // Start bit reads one from start until the first count clock
   always_ff @(posedge core_clk_in) begin
      if (srst_in) begin
         start_pending <= 1'b0;
      end else if (sw_start) begin
         start_pending <= 1'b1;
      end else if (!next_enable || (state == rdtmr_pkg::RDTMR_RUN && tick)) begin
         start_pending <= 1'b0;
      end
   end

   // Output pin level and enable
   always_ff @(posedge core_clk_in) begin
      if (srst_in) begin
         timer_output_pin_out <= 1'b0;
         timer_output_oe_out  <= 1'b0;
      end else begin
         timer_output_oe_out <= next_ctrl.output_pin_enable & next_enable;
         if (start) begin
            timer_output_pin_out <= next_ctrl.reload_select_bit
                                    ? next_ctrl.output_level_select
                                    : ~next_ctrl.output_level_select;
         end else if (underflow) begin
            timer_output_pin_out <= ctrl.reload_select_bit
                                    ? ~timer_output_pin_out
                                    : ctrl.output_level_select;
         end else if (state != rdtmr_pkg::RDTMR_RUN && !ctrl.reload_select_bit) begin
            timer_output_pin_out <= ctrl.output_level_select;
         end
      end
   end

   // Register reads; reading the upper count byte freezes the lower one
   always_ff @(posedge core_clk_in) begin
      if (srst_in) begin
         reg_rdata_out   <= rdtmr_pkg::BYTE_ZERO;
         count_low_latch <= rdtmr_pkg::BYTE_ZERO;
      end else if (reg_rd_in) begin
         case (reg_addr_in)
            rdtmr_pkg::ADDR_CTRL_UPPER: begin
               reg_rdata_out <= {2'h0, ctrl.count_clock_select, ctrl.operating_mode_select};
            end
            rdtmr_pkg::ADDR_CTRL_LOWER: begin
               reg_rdata_out <= {1'b0, ctrl.output_pin_enable, ctrl.output_level_select,
                                 ctrl.reload_select_bit, ctrl.underflow_irq_enable,
                                 underflow_flag, count_enable_bit, start_pending};
            end
            rdtmr_pkg::ADDR_VALUE_UPPER: begin
               reg_rdata_out   <= count[15:8];
               count_low_latch <= count[7:0];
            end
            rdtmr_pkg::ADDR_VALUE_LOWER: begin
               reg_rdata_out <= count_low_latch;
            end
            default: begin
               reg_rdata_out <= rdtmr_pkg::BYTE_ZERO;
            end
         endcase
      end else begin
         reg_rdata_out <= rdtmr_pkg::BYTE_ZERO;
      end
   end

   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (srst_in);

   // Own disable: the default one would mask every attempt of this check
   reset_state_a: assert property (disable iff (1'b0)
      srst_in ##1 srst_in |=> state == rdtmr_pkg::RDTMR_STOP
      && count == rdtmr_pkg::COUNT_RESET)
      else $error("reset did not give stopped zero counter");

   stop_hold_a: assert property (!next_enable |=>
      state == rdtmr_pkg::RDTMR_STOP && count == $past(count))
      else $error("stop did not hold counter");

   start_load_a: assert property (start |=>
      state == rdtmr_pkg::RDTMR_RUN && count == $past(reload_value_register))
      else $error("start did not load reload value");

   sw_start_a: assert property (wr_lower && reg_wdata_in[1:0] == 2'b11 |=>
      state == rdtmr_pkg::RDTMR_RUN)
      else $error("enable with start did not run");

   reload_a: assert property (underflow && ctrl.reload_select_bit |=>
      count == $past(reload_value_register) && state == rdtmr_pkg::RDTMR_RUN)
      else $error("reload mode did not reload");

   // Enable as it stands after this edge; a mask written here is legal
   flag_irq_a: assert property (underflow && next_ctrl.underflow_irq_enable |=>
      underflow_flag ##1 irq_out)
      else $error("underflow did not raise request");

   toggle_a: assert property (underflow && ctrl.reload_select_bit |=>
      timer_output_pin_out != $past(timer_output_pin_out))
      else $error("output did not toggle");

   oneshot_a: assert property (underflow && !ctrl.reload_select_bit |=>
      count == rdtmr_pkg::COUNT_ONESHOT && state == rdtmr_pkg::RDTMR_WAIT)
      else $error("one-shot did not halt at all ones");

   gate_hold_a: assert property (state == rdtmr_pkg::RDTMR_RUN && gate_mode && !gate_open
      && next_enable && !start |=> count == $past(count))
      else $error("counter moved with gate closed");

   no_resume_a: assert property (state == rdtmr_pkg::RDTMR_STOP && !start |=>
      state != rdtmr_pkg::RDTMR_RUN)
      else $error("counting resumed without start");

   wait_hold_a: assert property (state == rdtmr_pkg::RDTMR_WAIT && next_enable
      && !start |=> state == rdtmr_pkg::RDTMR_WAIT && count == $past(count))
      else $error("wait state left without a trigger");

   sw_trig_a: assert property (state != rdtmr_pkg::RDTMR_RUN && !event_mode && !gate_mode
      && sw_start |=> state == rdtmr_pkg::RDTMR_RUN)
      else $error("software start ignored in trigger mode");

endmodule

// *** verif/rdtmr_pin_src.sv ***
/*
 * Far-side model of the timer input pin: a source that gives triggers,
 * gate levels and event pulses.
 * Assumes the bench asks for a level and the pin follows one edge later.
 */
`timescale 1ns/10ps
module rdtmr_pin_src (
   input  wire logic core_clk_in,
   input  wire logic srst_in,
   input  wire logic level_in,
   output logic      pin_out
);
   // Held until the bench asks again, so gate levels stay put
   always_ff @(posedge core_clk_in) begin
      if (srst_in) begin
         pin_out <= 1'b0;
      end else begin
         pin_out <= level_in;
      end
   end
endmodule

// *** verif/tb_top.sv ***
/*
 * Self-checking bench for the reload down timer: register tasks, pin source,
 * event, stop, trigger and gate scenarios.
 * Assumes rdtmr_top with one-cycle register strobes and read data next cycle.
 */
`timescale 1ns/10ps
module tb_top;
   logic        core_clk_in, srst_in, reg_wr_in, reg_rd_in, lvl, pin, opin, oe, irq;
   logic [1:0]  reg_addr_in;
   logic [7:0]  reg_wdata_in, rdata, rb;
   logic [15:0] n, cnt;
   int          n_mismatch, n_compared, i, m;

   rdtmr_top u_rdtmr_top (.core_clk_in(core_clk_in), .srst_in(srst_in),
      .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
      .reg_rd_in(reg_rd_in), .reg_rdata_out(rdata), .timer_input_pin_in(pin),
      .timer_output_pin_out(opin), .timer_output_oe_out(oe), .irq_out(irq));
   rdtmr_pin_src u_rdtmr_pin_src (.core_clk_in(core_clk_in), .srst_in(srst_in),
      .level_in(lvl), .pin_out(pin));

   task automatic summarize();
      $display("compared %0d mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_bit(input logic got, input logic exp);
      chk_val({15'h0000, got}, {15'h0000, exp});
   endtask
   task automatic cyc(input int k);
      repeat (k) @(posedge core_clk_in);
   endtask
   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      @(posedge core_clk_in);
      reg_addr_in  <= a;
      reg_wdata_in <= d;
      reg_wr_in    <= 1'b1;
      @(posedge core_clk_in);
      reg_wr_in <= 1'b0;
   endtask
   task automatic rd(input logic [1:0] a);
      @(posedge core_clk_in);
      reg_addr_in <= a;
      reg_rd_in   <= 1'b1;
      @(posedge core_clk_in);
      reg_rd_in <= 1'b0;
      #1 rb = rdata;
   endtask
   // Upper first: it freezes the lower byte
   task automatic rd_cnt();
      rd(2'h2);
      cnt[15:8] = rb;
      rd(2'h3);
      cnt[7:0] = rb;
   endtask
   task automatic set_reload(input logic [15:0] v);
      wr(2'h2, v[15:8]);
      wr(2'h3, v[7:0]);
   endtask
   // Eight cycles covers pin flop, sync, flag and irq delay
   task automatic tog(input int k);
      repeat (k) begin
         @(posedge core_clk_in);
         lvl <= ~lvl;
         cyc(8);
      end
   endtask
   task automatic wait_irq(input int b);
      for (int k = 0; k < b && irq !== 1'b1; k++) @(posedge core_clk_in);
      if (irq !== 1'b1) begin
         n_mismatch++;
         $display("wrong value at %0t: no interrupt in time", $time);
         summarize();
      end
   endtask
   // Decrements from t toggles starting low, t even
   function automatic int decs(input int md, input int t);
      return (md == 3) ? t : t / 2;
   endfunction

   initial begin
      core_clk_in = 1'b0;
      forever #50 core_clk_in = ~core_clk_in;
   end

   initial begin
      srst_in = 1'b1;
      reg_wr_in = 1'b0;
      reg_rd_in = 1'b0;
      reg_addr_in = 2'h0;
      reg_wdata_in = 8'h00;
      lvl = 1'b0;
      n_mismatch = 0;
      n_compared = 0;
      void'($urandom(32'he6e8));
      cyc(6);
      srst_in <= 1'b0;
      rd(2'h1);
      chk_val({8'h00, rb}, 16'h0000);
      rd_cnt();
      chk_val(cnt, rdtmr_pkg::COUNT_RESET);
      chk_bit(oe, 1'b0);
      $display("test reset done");
      for (m = 1; m < 4; m++) begin
         @(posedge core_clk_in);
         lvl <= 1'b0;
         n = 16'($urandom_range(3, 9));
         set_reload(n);
         wr(2'h0, {2'b00, rdtmr_pkg::CSEL_EVENT, m[2:0]});
         rd(2'h0);
         chk_val({8'h00, rb}, {10'h000, rdtmr_pkg::CSEL_EVENT, m[2:0]});
         wr(2'h1, 8'h5b | (m[0] ? 8'h20 : 8'h00));
         cyc(2);
         rd_cnt();
         chk_val(cnt, n);
         chk_bit(opin, m[0]);
         chk_bit(oe, 1'b1);
         tog(2);
         rd_cnt();
         chk_val(cnt, n - 16'(decs(m, 2)));
         i = int'(n) - decs(m, 2) + 1;
         tog((m == 3) ? i : 2 * i);
         chk_bit(irq, 1'b1);
         chk_bit(opin, ~m[0]);
         rd_cnt();
         chk_val(cnt, n);
         wr(2'h1, 8'h5a | (m[0] ? 8'h20 : 8'h00));
         cyc(3);
         chk_bit(irq, 1'b0);
         wr(2'h1, 8'h00);
      end
      $display("test event reload done");
      set_reload(16'h0001);
      wr(2'h0, 8'h39);
      wr(2'h1, 8'h4b);
      cyc(2);
      chk_bit(opin, 1'b1);
      tog(4);
      chk_bit(opin, 1'b0);
      chk_bit(irq, 1'b1);
      tog(4);
      rd_cnt();
      chk_val(cnt, rdtmr_pkg::COUNT_ONESHOT);
      n = 16'($urandom_range(20, 200));
      set_reload(n);
      wr(2'h1, 8'h13);
      tog(2);
      wr(2'h1, 8'h10);
      tog(2);
      rd_cnt();
      chk_val(cnt, n - 16'h0001);
      wr(2'h1, 8'h12);
      tog(2);
      rd_cnt();
      chk_val(cnt, n - 16'h0001);
      $display("test one-shot and stop done");
      for (m = 1; m < 4; m++) begin
         @(posedge core_clk_in);
         lvl <= (m == 2);
         set_reload(16'($urandom_range(2, 6)));
         wr(2'h0, {2'b00, 3'($urandom_range(0, 2)), m[2:0]});
         wr(2'h1, 8'h4a);
         cyc(20);
         chk_bit(irq, 1'b0);
         chk_bit(opin, 1'b0);
         tog(1);
         wait_irq(600);
         wr(2'h1, 8'h00);
      end
      wr(2'h1, 8'h4b);
      wait_irq(600);
      wr(2'h1, 8'h00);
      $display("test external trigger done");
      for (m = 4; m < 8; m++) begin
         n = 16'($urandom_range(2, 9));
         @(posedge core_clk_in);
         lvl <= ~m[0];
         set_reload(n);
         wr(2'h0, m[7:0]);
         wr(2'h1, 8'h0b);
         cyc(30);
         rd_cnt();
         chk_val(cnt, n);
         @(posedge core_clk_in);
         lvl <= m[0];
         wait_irq(600);
         wr(2'h1, 8'h00);
      end
      $display("test gate done");
      summarize();
   end
endmodule
